//--- hw/asbl_params.svh
// constants for the asynchronous sram byte-lane controller
// Summary of operation
// - write starts when all three are low and ends when any rises
// - controller holds write data stable across the terminating edge
// - controller holds write strobe high throughout every read
// - controller presents the address no later than select falling
`ifndef ASBL_PARAMS_SVH
`define ASBL_PARAMS_SVH
`define ASBL_ADDR_W 15
`define ASBL_DATA_W 16
`define ASBL_LANE_W 8
`define ASBL_CLK_PS 25000
// read access time and write strobe width, picoseconds
`define ASBL_T_ACC_PS 15000
`define ASBL_T_PWE_PS 10000
`define ASBL_T_SD_PS 8000
// least times round up to whole cycles
`define ASBL_CYC(t) (((t) + `ASBL_CLK_PS - 1) / `ASBL_CLK_PS)
`define ASBL_RD_CYC `ASBL_CYC(`ASBL_T_ACC_PS)
`define ASBL_WR_CYC `ASBL_CYC(`ASBL_T_PWE_PS)
`endif

//--- hw/asbl_pkg.sv
// types for the asynchronous sram byte-lane controller
package asbl_pkg;
    typedef enum logic [2:0] {
        ASBL_IDLE = 3'b000,
        ASBL_RSET = 3'b001,
        ASBL_RACC = 3'b010,
        ASBL_WSET = 3'b011,
        ASBL_WPUL = 3'b100,
        ASBL_WEND = 3'b101
    } asbl_state_t;
endpackage

//--- hw/asbl_wait_ctr.sv
// small down counter that times strobe phases
`timescale 1ns/1ps
`default_nettype none
module asbl_wait_ctr (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic load,
    input wire logic [3:0] load_val,
    output logic done
);
    logic [3:0] cnt_reg;
    // reload on request, otherwise count down to zero and rest there
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 4'h0;
        end else if (ce) begin
            if (load) begin
                cnt_reg <= load_val;
            end else if (cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
    assign done = (cnt_reg == 4'h0) && !load;
endmodule // asbl_wait_ctr
`default_nettype wire

//--- hw/asbl_ctrl.sv
// host-side controller driving an asynchronous 16-bit byte-lane sram
`timescale 1ns/1ps
`default_nettype none
`include "asbl_params.svh"
module asbl_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`ASBL_ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_lane,
    input wire logic [`ASBL_DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [`ASBL_DATA_W-1:0] rsp_rdata,
    output logic [`ASBL_ADDR_W-1:0] mem_addr,
    output logic chip_select_n,
    output logic output_drive_enable_n,
    output logic write_strobe_n,
    output logic low_byte_lane_n,
    output logic high_byte_lane_n,
    input wire logic [`ASBL_DATA_W-1:0] mem_dq_in,
    output logic [`ASBL_DATA_W-1:0] mem_dq_out,
    output logic [`ASBL_DATA_W-1:0] mem_dq_oe
);
    import asbl_pkg::*;

    asbl_state_t state_reg, state_next;
    logic [`ASBL_ADDR_W-1:0] addr_reg;
    logic [`ASBL_DATA_W-1:0] wdata_reg, rdata_reg;
    logic [1:0] lane_reg;
    logic rsp_reg;
    logic wait_load, wait_done;
    logic [3:0] wait_val;

    // lane mask to pin mask: bit 0 low byte, bit 1 high byte
    function automatic logic [`ASBL_DATA_W-1:0] lane_mask(input logic [1:0] l);
        lane_mask = {{`ASBL_LANE_W{l[1]}}, {`ASBL_LANE_W{l[0]}}};
    endfunction

    wire idle_st = (state_reg == ASBL_IDLE);
    wire rd_st = (state_reg == ASBL_RSET) || (state_reg == ASBL_RACC);
    wire wr_st = (state_reg == ASBL_WSET) || (state_reg == ASBL_WPUL)
                 || (state_reg == ASBL_WEND);
    // a request with no lane selected would store nothing, so it is never started
    wire take = ce && idle_st && req_valid && (req_lane != 2'b00);

    assign req_ready = idle_st && (req_lane != 2'b00);

    // next-state decode
    always_comb begin
        state_next = state_reg;
        wait_load = 1'b0;
        wait_val = 4'h0;
        case (state_reg)
            ASBL_IDLE: begin
                if (take) begin
                    state_next = req_write ? ASBL_WSET : ASBL_RSET;
                end
            end
            ASBL_RSET: begin
                state_next = ASBL_RACC;
                wait_load = 1'b1;
                wait_val = 4'(`ASBL_RD_CYC);
            end
            ASBL_RACC: begin
                if (wait_done) begin
                    state_next = ASBL_IDLE;
                end
            end
            ASBL_WSET: begin
                state_next = ASBL_WPUL;
                wait_load = 1'b1;
                wait_val = 4'(`ASBL_WR_CYC);
            end
            ASBL_WPUL: begin
                if (wait_done) begin
                    state_next = ASBL_WEND;
                end
            end
            ASBL_WEND: begin
                state_next = ASBL_IDLE;
            end
            default: begin
                state_next = ASBL_IDLE;
            end
        endcase
    end

    asbl_wait_ctr u_wait (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .load(wait_load),
        .load_val(wait_val),
        .done(wait_done)
    );

    // state and captured request; address latched on the same edge that select falls
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ASBL_IDLE;
            addr_reg <= 15'h0000;
            wdata_reg <= 16'h0000;
            lane_reg <= 2'b00;
        end else if (ce) begin
            state_reg <= state_next;
            if (take) begin
                addr_reg <= req_addr;
                wdata_reg <= req_wdata;
                lane_reg <= req_lane;
            end
        end
    end

    // read data sampled at the end of access, unused lanes zero
    wire rd_capture = (state_reg == ASBL_RACC) && wait_done;
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 16'h0000;
            rsp_reg <= 1'b0;
        end else if (ce) begin
            rsp_reg <= rd_capture || (state_reg == ASBL_WEND);
            if (rd_capture) begin
                rdata_reg <= mem_dq_in & lane_mask(lane_reg);
            end
        end
    end
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;

    // pin drive; strobe low only in the pulse state so select, lanes and data
    // bracket it and the strobe edge alone ends the write
    assign mem_addr = addr_reg;
    assign chip_select_n = idle_st;
    assign write_strobe_n = (state_reg != ASBL_WPUL);
    assign output_drive_enable_n = !rd_st;
    assign low_byte_lane_n = idle_st || !lane_reg[0];
    assign high_byte_lane_n = idle_st || !lane_reg[1];
    // data held through the end state, one cycle past the strobe rising edge
    assign mem_dq_out = wdata_reg;
    assign mem_dq_oe = wr_st ? lane_mask(lane_reg) : 16'h0000;

    // sequence: strobe pulse followed by the hold state
    sequence s_wr_end;
        !write_strobe_n ##1 write_strobe_n;
    endsequence

    // sequence: select falls with the output drive already enabled, a read
    sequence s_rd_start;
        $fell(chip_select_n) && !output_drive_enable_n;
    endsequence

    // sequence: select falls with the output drive held off, a write
    sequence s_wr_start;
        $fell(chip_select_n) && output_drive_enable_n;
    endsequence

    // sequence: strobe low for the two sampled cycles of the pulse state
    sequence s_wr_pulse;
        !write_strobe_n [*2];
    endsequence

    // sequence: select released together with the one-cycle answer
    sequence s_release;
        chip_select_n && rsp_valid;
    endsequence

    a_strobe_in_read: assert property (@(posedge clk) disable iff (srst)
        !output_drive_enable_n |-> write_strobe_n)
        else $error("write strobe low during read");
    a_data_hold_end: assert property (@(posedge clk) disable iff (srst || !ce)
        s_wr_end |-> (mem_dq_oe != 16'h0000) && $stable(mem_dq_out) && !chip_select_n)
        else $error("write data not held past strobe");
    a_write_overlap: assert property (@(posedge clk) disable iff (srst)
        !write_strobe_n |-> !chip_select_n && !(low_byte_lane_n && high_byte_lane_n))
        else $error("strobe without select and lane");
    a_addr_stable: assert property (@(posedge clk) disable iff (srst || !ce)
        !chip_select_n && !$past(chip_select_n) |-> $stable(mem_addr))
        else $error("address moved while selected");
    a_no_bus_fight: assert property (@(posedge clk) disable iff (srst)
        !output_drive_enable_n |-> mem_dq_oe == 16'h0000)
        else $error("host drives during read");
    a_lane_drive: assert property (@(posedge clk) disable iff (srst)
        (mem_dq_oe != 16'h0000) |-> mem_dq_oe == lane_mask(lane_reg))
        else $error("drive mask mismatches lanes");
    a_idle_float: assert property (@(posedge clk) disable iff (srst)
        chip_select_n |-> mem_dq_oe == 16'h0000 && write_strobe_n)
        else $error("activity while deselected");
    // the strobe must still be low one edge after it fell, or the pulse is short
    a_pulse_width: assert property (@(posedge clk) disable iff (srst || !ce)
        $fell(write_strobe_n) |=> !write_strobe_n)
        else $error("strobe pulse too short");

    // read frame: drive enabled for three sampled cycles, then release and answer;
    // the strobe never moves inside it
    a_read_frame: assert property (@(posedge clk) disable iff (srst || !ce)
        s_rd_start |-> (!output_drive_enable_n && write_strobe_n) [*3] ##1
            (output_drive_enable_n && rsp_valid))
        else $error("read frame out of order");

    // write frame: setup cycle, strobe pulse, hold cycle, then release and answer
    a_write_order: assert property (@(posedge clk) disable iff (srst || !ce)
        s_wr_start |-> write_strobe_n ##1 s_wr_pulse ##1
            (write_strobe_n && !chip_select_n) ##1 s_release)
        else $error("write frame out of order");

    // the address on the pins at select falling is the one that was taken
    a_addr_at_select: assert property (@(posedge clk) disable iff (srst || !ce)
        $fell(chip_select_n) |-> mem_addr == $past(req_addr))
        else $error("address not valid at select");

    // the answer is a single-cycle pulse, so a caller cannot count it twice
    a_rsp_pulse: assert property (@(posedge clk) disable iff (srst || !ce)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");

    // coming out of reset every control pin is released and nothing is driven
    a_reset_idle: assert property (@(posedge clk) disable iff (!ce)
        $past(srst) |-> chip_select_n && write_strobe_n && mem_dq_oe == 16'h0000)
        else $error("pins active after reset");
endmodule // asbl_ctrl
`default_nettype wire

//--- sim/asbl_sram_model.sv
// behavioural 32k x 16 byte-lane static ram on the far side
`timescale 1ns/1ps
`default_nettype none
`include "asbl_params.svh"
module asbl_sram_model (
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic lo_n,
    input wire logic hi_n,
    input wire logic [`ASBL_ADDR_W-1:0] addr,
    input wire logic [`ASBL_DATA_W-1:0] dq_in,
    output logic [`ASBL_DATA_W-1:0] dq_out,
    output logic [`ASBL_DATA_W-1:0] dq_drv
);
    logic [`ASBL_DATA_W-1:0] mem_arr [0:32767];
    wire logic wr_on = !cs_n && !we_n;
    wire logic rd_on = !cs_n && !oe_n && we_n;
    // level-sensitive store: the array follows data for as long as the overlap lasts
    always @(wr_on, lo_n, hi_n, addr, dq_in) begin
        if (wr_on && !lo_n) mem_arr[addr][7:0] = dq_in[7:0];
        if (wr_on && !hi_n) mem_arr[addr][15:8] = dq_in[15:8];
    end
    // per-lane drive, never while the strobe is low
    assign dq_drv = {{8{rd_on && !hi_n}}, {8{rd_on && !lo_n}}};
    assign dq_out = mem_arr[addr];
endmodule // asbl_sram_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the byte-lane sram controller
`timescale 1ns/1ps
`default_nettype none
`include "asbl_params.svh"
module tb;
    logic clk = 0;
    logic srst = 1;
    logic req_valid = 0;
    logic req_write = 0;
    logic [14:0] req_addr = 15'h0000;
    logic [1:0] req_lane = 2'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] dq_last = 16'h0000;
    wire logic req_ready, rsp_valid, cs_n, oe_n, we_n, lo_n, hi_n;
    wire logic [14:0] m_addr;
    wire logic [15:0] rdata, h_out, h_oe, m_out, m_drv, dq_bus;
    int fail_count = 0;
    int n_checks = 0;
    asbl_ctrl DUT (.clk(clk), .srst(srst), .ce(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_lane(req_lane), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rdata), .mem_addr(m_addr), .chip_select_n(cs_n),
        .output_drive_enable_n(oe_n), .write_strobe_n(we_n), .low_byte_lane_n(lo_n),
        .high_byte_lane_n(hi_n), .mem_dq_in(dq_bus), .mem_dq_out(h_out), .mem_dq_oe(h_oe));
    asbl_sram_model ram (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .lo_n(lo_n), .hi_n(hi_n),
        .addr(m_addr), .dq_in(dq_bus), .dq_out(m_out), .dq_drv(m_drv));
    // undriven bits show the inverse of the last level, so a stale value never matches
    assign dq_bus = (h_oe & h_out) | (m_drv & m_out) | (~(h_oe | m_drv) & ~dq_last);
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        dq_last <= dq_bus;
        if (|(h_oe & m_drv)) check(h_oe & m_drv, 16'h0000);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic hang;
        fail_count++;
        $display("ERROR at %0t: handshake timed out", $time);
        tally_and_finish;
    endtask
    // one request from a falling edge to its response pulse
    task automatic xfer(input logic w, input logic [14:0] a, input logic [1:0] l,
        input logic [15:0] d);
        int i;
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_lane = l;
        req_wdata = d;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
        if (req_ready !== 1'b1) hang;
        @(negedge clk);
        req_valid = 0;
        for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (rsp_valid !== 1'b1) hang;
        // read answers three edges after the take edge, write four
        check(16'(i), w ? 16'h0004 : 16'h0003);
    endtask
    task automatic t_full;
        xfer(1, 15'h7FFF, 2'h3, 16'h1234);
        xfer(1, 15'h0000, 2'h3, 16'hABCD);
        xfer(0, 15'h7FFF, 2'h3, 16'h0000);
        check(rdata, 16'h1234);
        xfer(0, 15'h0000, 2'h3, 16'h0000);
        check(rdata, 16'hABCD);
        $display("full word test done");
    endtask
    task automatic t_lanes;
        xfer(1, 15'h0005, 2'h3, 16'h5A5A);
        xfer(1, 15'h0005, 2'h2, 16'hC3F0);
        xfer(0, 15'h0005, 2'h3, 16'h0000);
        check(rdata, 16'hC35A);
        xfer(0, 15'h0005, 2'h2, 16'h0000);
        check(rdata, 16'hC300);
        xfer(0, 15'h0005, 2'h1, 16'h0000);
        check(rdata, 16'h005A);
        $display("byte lane test done");
    endtask
    task automatic t_refuse;
        req_valid = 1;
        req_write = 1;
        req_addr = 15'h0005;
        req_lane = 2'h0;
        req_wdata = 16'hFFFF;
        repeat (3) @(negedge clk);
        check({15'h0, req_ready}, 16'h0000);
        check({11'h0, cs_n, oe_n, we_n, lo_n, hi_n}, 16'h001F);
        // request stays valid; the read below simply replaces its fields
        xfer(0, 15'h0005, 2'h3, 16'h0000);
        check(rdata, 16'hC35A);
        $display("refused request test done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 0;
        @(negedge clk);
        t_full;
        t_lanes;
        t_refuse;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
